//--- src/abr_defines.vh
// constants for the autobias register bank: offsets, fields, reset values, timing
`ifndef ABR_DEFINES_VH
`define ABR_DEFINES_VH
`define ABR_ADDR_SYSTEM_CONTROL     5'h00
`define ABR_ADDR_CARRIER_SENSE      5'h01
`define ABR_ADDR_CARRIER_DRIVER     5'h02
`define ABR_ADDR_CARRIER_FINAL      5'h03
`define ABR_ADDR_PEAKING_SENSE      5'h04
`define ABR_ADDR_PEAKING_DRIVER     5'h05
`define ABR_ADDR_PEAKING_FINAL      5'h06
`define ABR_ADDR_TEMPERATURE        5'h0f
`define ABR_ADDR_UNLOCK_KEY         5'h11
`define ABR_BIT_SOFT_RESET          6
`define ABR_BIT_REFRESH             5
`define ABR_VERSION_MSB             3
`define ABR_SENSE_MSB               5
`define ABR_UNLOCK_PASSCODE         8'he3
`define ABR_SYSCTL_RESET            8'h00
`define ABR_SENSE_MASK              8'h3f
`define ABR_BIAS_COUNT              6
`define ABR_LOAD_TIME_NS            200
`define ABR_CLK_PERIOD_NS           40
`endif

//--- src/abr_factory_store.v
// factory value store: read-only bias words, sequenced copy-out after a load request
`default_nettype none
module abr_factory_store (
   input  wire       i_core_clk,
   input  wire       i_rst_b,
   input  wire       i_ce,
   input  wire       i_load_req,
   input  wire [47:0] i_fuse_bits,
   output reg        o_busy,
   output reg        o_wr,
   output reg  [2:0] o_idx,
   output reg  [7:0] o_data
);
`include "abr_defines.vh"
   // no write path exists into the store; contents come only from fuse bits
   reg  [7:0] store [0:`ABR_BIAS_COUNT-1];
   reg  [2:0] cnt;
   genvar g;
   generate
      for (g = 0; g < `ABR_BIAS_COUNT; g = g + 1) begin : g_store
         always @* begin
            store[g] = i_fuse_bits[8*g +: 8];
         end
      end
   endgenerate
   always @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_busy <= 1'b1;
         o_wr   <= 1'b0;
         o_idx  <= 3'h0;
         o_data <= 8'h00;
         cnt    <= 3'h0;
      end else if (i_ce) begin
         o_wr <= 1'b0;
         if (i_load_req && !o_busy) begin
            o_busy <= 1'b1;
            cnt    <= 3'h0;
         end else if (o_busy) begin
            o_wr   <= 1'b1;
            o_idx  <= cnt;
            o_data <= store[cnt];
            if ({29'h0, cnt} == `ABR_BIAS_COUNT - 1) begin
               o_busy <= 1'b0;
            end
            cnt <= cnt + 3'h1;
         end
      end
   end
endmodule
`default_nettype wire

//--- src/abr_register_bank.v
// autobias register bank with factory load, soft reset, refresh and override unlock
`default_nettype none
// Behaviour
// - after power-on or any reset the factory values load into the bias registers unaided.
// - host writes to bias registers take effect only after the override unlock.
// - a reset or power cycle drops override values and restores factory values.
// - the factory store has no write path from the host.
// - nine eight-bit registers live in addresses 0 to 17.
// - address 0 holds soft reset, refresh and the chip version.
// - the four-bit chip version in address 0 is read-only.
// - addresses 1 to 6 hold the six bias settings copied from the factory store.
// - sense registers keep six bits; bits 7 and 6 read zero and store nothing.
// - address 15 returns the temperature reading and ignores writes.
// - writing E3 hex to write-only address 17 enables the override mode.
// - writing 1 to bit 6 of address 0 drops override mode, clears refresh and reloads factory bias values; bit 6 stays set.
// - writing 1 to bit 5 of address 0 reloads factory values into bias registers.
module abr_register_bank (
   input  wire        i_core_clk,
   input  wire        i_rst_b,
   input  wire        i_ce,
   input  wire        i_wr_en,
   input  wire        i_rd_en,
   input  wire [4:0]  i_addr,
   input  wire [7:0]  i_wdata,
   input  wire [7:0]  i_temperature,
   input  wire [47:0] i_fuse_bits,
   output reg  [7:0]  o_rdata,
   output reg         o_rvalid,
   output reg         o_override_mode,
   output reg         o_load_busy,
   output reg  [47:0] o_bias_settings
);
`include "abr_defines.vh"
   // arbitrary version value
   parameter [3:0] CHIP_VERSION = 4'h5;

   reg  [7:0] sysctl;
   reg  [7:0] bias [0:`ABR_BIAS_COUNT-1];
   reg        eng_mode;
   reg  [7:0] temp_s1;
   reg  [7:0] temp_s2;
   reg        soft_rst_q;
   wire       st_busy;
   wire       st_wr;
   wire [2:0] st_idx;
   wire [7:0] st_data;
   reg  [7:0] next_rdata;
   wire       soft_rst_rise;
   wire       refresh_req;
   wire       bias_write;

   function is_sense;
      input [2:0] idx;
      begin
         is_sense = (idx == 3'd0) || (idx == 3'd3);
      end
   endfunction

   function [2:0] bias_index;
      input [4:0] addr;
      begin
         bias_index = addr[2:0] - 3'h1;
      end
   endfunction

   function in_bias_range;
      input [4:0] addr;
      begin
         in_bias_range = (addr >= `ABR_ADDR_CARRIER_SENSE) &&
                         (addr <= `ABR_ADDR_PEAKING_FINAL);
      end
   endfunction

   assign soft_rst_rise = sysctl[`ABR_BIT_SOFT_RESET] & ~soft_rst_q;
   // refresh fires while its bit is set; the store ignores it while busy
   assign refresh_req = sysctl[`ABR_BIT_REFRESH] | soft_rst_rise;
   assign bias_write = i_wr_en && in_bias_range(i_addr) && eng_mode && !st_busy;

   abr_factory_store u_store (
      .i_core_clk (i_core_clk),
      .i_rst_b    (i_rst_b),
      .i_ce       (i_ce),
      .i_load_req (refresh_req),
      .i_fuse_bits(i_fuse_bits),
      .o_busy     (st_busy),
      .o_wr       (st_wr),
      .o_idx      (st_idx),
      .o_data     (st_data)
   );

   // temperature comes from the analog side, so it is synchronised first
   always @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         temp_s1 <= 8'h00;
         temp_s2 <= 8'h00;
      end else if (i_ce) begin
         temp_s1 <= i_temperature;
         temp_s2 <= temp_s1;
      end
   end

   always @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sysctl     <= `ABR_SYSCTL_RESET;
         soft_rst_q <= 1'b0;
         eng_mode   <= 1'b0;
      end else if (i_ce) begin
         soft_rst_q <= sysctl[`ABR_BIT_SOFT_RESET];
         if (i_wr_en && i_addr == `ABR_ADDR_SYSTEM_CONTROL) begin
            // only the two control bits store; version and bits 7,4 ignore writes
            sysctl[`ABR_BIT_SOFT_RESET] <= i_wdata[`ABR_BIT_SOFT_RESET];
            sysctl[`ABR_BIT_REFRESH]    <= i_wdata[`ABR_BIT_REFRESH];
         end
         if (soft_rst_rise) begin
            eng_mode <= 1'b0;
            sysctl[`ABR_BIT_REFRESH] <= 1'b0;
         end else if (i_wr_en && i_addr == `ABR_ADDR_UNLOCK_KEY &&
                      i_wdata == `ABR_UNLOCK_PASSCODE) begin
            eng_mode <= 1'b1;
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < `ABR_BIAS_COUNT; g = g + 1) begin : g_bias
         localparam [2:0] IDX = g;
         always @(posedge i_core_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
               bias[g] <= 8'h00;
            end else if (i_ce) begin
               // factory copy wins over any host write in the same cycle
               if (st_wr && st_idx == IDX) begin
                  if (is_sense(IDX)) begin
                     bias[g] <= st_data & `ABR_SENSE_MASK;
                  end else begin
                     bias[g] <= st_data;
                  end
               end else if (bias_write && bias_index(i_addr) == IDX) begin
                  if (is_sense(IDX)) begin
                     bias[g] <= i_wdata & `ABR_SENSE_MASK;
                  end else begin
                     bias[g] <= i_wdata;
                  end
               end
            end
         end
      end
   endgenerate

   always @* begin
      next_rdata = 8'h00;
      if (i_addr == `ABR_ADDR_SYSTEM_CONTROL) begin
         next_rdata = {1'b0, sysctl[`ABR_BIT_SOFT_RESET], sysctl[`ABR_BIT_REFRESH],
                       1'b0, CHIP_VERSION};
      end else if (in_bias_range(i_addr)) begin
         next_rdata = bias[bias_index(i_addr)];
      end else if (i_addr == `ABR_ADDR_TEMPERATURE) begin
         next_rdata = temp_s2;
      end
      // the unlock key reads as zero: it is write-only
   end

   always @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_rdata         <= 8'h00;
         o_rvalid        <= 1'b0;
         o_override_mode <= 1'b0;
         o_load_busy     <= 1'b1;
         o_bias_settings <= 48'h0000_0000_0000;
      end else if (i_ce) begin
         o_rvalid        <= i_rd_en;
         if (i_rd_en) begin
            o_rdata <= next_rdata;
         end
         o_override_mode <= eng_mode;
         o_load_busy     <= st_busy;
         o_bias_settings <= {bias[5], bias[4], bias[3], bias[2], bias[1], bias[0]};
      end
   end
endmodule
`default_nettype wire

//--- tb/abr_props.sv
// port checker for the autobias register bank
`default_nettype none
module abr_props #(parameter logic [3:0] CHIP_VERSION = 4'h5) (
   input wire logic        i_core_clk, i_rst_b, i_ce, i_wr_en, i_rd_en,
   input wire logic        o_rvalid, o_override_mode, o_load_busy,
   input wire logic [4:0]  i_addr,
   input wire logic [7:0]  i_wdata, i_temperature, o_rdata,
   input wire logic [47:0] i_fuse_bits, o_bias_settings);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_b);
   wire logic rd = i_ce && i_rd_en;
   a_rvalid_pulse: assert property (rd |=> o_rvalid)
      else $error("read not answered");
   a_rvalid_cause: assert property (o_rvalid |-> $past(rd))
      else $error("valid without read");
   a_version_ro: assert property (rd && i_addr == 5'h00
      |=> !o_rdata[7] && !o_rdata[4] && o_rdata[3:0] == CHIP_VERSION)
      else $error("bad control readback");
   a_temp_ro: assert property (rd && i_addr == 5'h0f && $past(i_temperature) == i_temperature
      && $past(i_temperature, 3) == i_temperature |=> o_rdata == $past(i_temperature))
      else $error("bad temperature read");
   a_reserved_zero: assert property (rd && i_addr inside {[5'h07:5'h0e], 5'h10, 5'h11}
      |=> o_rdata == 8'h00) else $error("reserved read not zero");
   a_unlock_key: assert property (i_ce && i_wr_en && i_addr == 5'h11 && i_wdata == 8'he3
      |-> ##2 o_override_mode) else $error("unlock missed");
   a_sense_bits: assert property (o_bias_settings[7:6] == 2'b00
      && o_bias_settings[31:30] == 2'b00) else $error("sense upper bits set");
   // bias may only move during a factory copy or in override mode
   a_bias_locked: assert property ($changed(o_bias_settings) |-> o_load_busy
      || $past(o_load_busy) || $past(o_load_busy, 3) || $past(o_override_mode))
      else $error("bias moved while locked");
   c_unlock: cover property ($rose(o_override_mode));
   c_copy_end: cover property ($fell(o_load_busy));
   c_reserved: cover property (rd && i_addr == 5'h10);
endmodule
bind abr_register_bank abr_props #(.CHIP_VERSION(CHIP_VERSION)) u_props (.*);
`default_nettype wire

//--- tb/autobias_register_bank_otp_tb.sv
// self-checking bench for the autobias register bank
`default_nettype none
module autobias_register_bank_otp_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [47:0] FUSE = 48'h1122_c733_44ea;
   localparam logic [47:0] BIAS = 48'h1122_0733_442a;
   logic        clk = 0, rst_b = 0, ce = 1, wr_en = 0, rd_en = 0, rvalid, ovr, busy;
   logic [4:0]  addr = 0;
   logic [7:0]  wdata = 0, temp = 8'h9c, rdata;
   logic [47:0] bias;
   int          bad_count = 0, cmp_count = 0;
   always #20 clk = ~clk;
   abr_register_bank uut (.i_core_clk(clk), .i_rst_b(rst_b), .i_ce(ce), .i_wr_en(wr_en),
      .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata), .i_temperature(temp),
      .i_fuse_bits(FUSE), .o_rdata(rdata), .o_rvalid(rvalid), .o_override_mode(ovr),
      .o_load_busy(busy), .o_bias_settings(bias));
   task automatic chk(input logic [47:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 {wr_en, addr, wdata} = {1'b1, a, d};
      @(posedge clk);
      #1 wr_en = 0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] e);
      @(posedge clk);
      #1 {rd_en, addr} = {1'b1, a};
      @(posedge clk);
      #1 rd_en = 0;
      chk(rvalid, 1);
      chk(rdata, e);
   endtask
   // busy rises a couple of cycles after a request, so give it time first
   task automatic idle;
      repeat (3) @(posedge clk);
      #1;
      for (int n = 0; n < 40 && busy !== 0; n++) begin
         @(posedge clk);
         #1;
      end
      // the bias outputs trail the busy flag by one register stage
      repeat (2) @(posedge clk);
      #1 chk(busy, 0);
   endtask
   task automatic test_done;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #100000;
      bad_count++;
      test_done;
   end
   initial begin
      repeat (10) @(posedge clk);
      #1 rst_b = 1;
      idle;
      chk(bias, BIAS);
      for (int i = 0; i < 6; i++) rd(5'(i + 1), BIAS[8*i +: 8]);
      rd(5'h00, 8'h05);
      $display("test load done");
      wr(5'h00, 8'h9f);
      rd(5'h00, 8'h05);
      wr(5'h02, 8'h5a);
      rd(5'h02, 8'h44);
      wr(5'h0f, 8'h00);
      wr(5'h10, 8'hff);
      rd(5'h0f, 8'h9c);
      for (int i = 7; i < 18; i++) if (i != 15) rd(5'(i), 8'h00);
      wr(5'h11, 8'he2);
      chk(ovr, 0);
      $display("test locked done");
      wr(5'h11, 8'he3);
      @(posedge clk);
      #1 chk(ovr, 1);
      wr(5'h02, 8'h5a);
      wr(5'h01, 8'hff);
      rd(5'h02, 8'h5a);
      rd(5'h01, 8'h3f);
      wr(5'h00, 8'h20);
      wr(5'h00, 8'h00);
      idle;
      rd(5'h02, 8'h44);
      chk(ovr, 1);
      wr(5'h03, 8'h77);
      wr(5'h00, 8'h40);
      wr(5'h00, 8'h00);
      idle;
      chk(ovr, 0);
      chk(bias, BIAS);
      $display("test override done");
      wr(5'h11, 8'he3);
      wr(5'h03, 8'h77);
      #1 rst_b = 0;
      repeat (2) @(posedge clk);
      #1 rst_b = 1;
      idle;
      chk(ovr, 0);
      chk(bias, BIAS);
      rd(5'h03, 8'h33);
      $display("test hard reset done");
      test_done;
   end
endmodule
`default_nettype wire
